//--- verilog/ser_status_top.v
// ser_status_top.v: measurement, questionable and operation event registers.
// assumes event inputs on core_clk; host reads by select and strobe, the
// answer is a 16-bit binary value plus its decimal digits for the talker.
`timescale 1ns/1ps
`include "ser_consts.vh"
module ser_status_top (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // measurement status
   input  wire        reading_overflow,
   input  wire        lower_bound_one_flag,
   input  wire        upper_bound_one_flag,
   input  wire        lower_bound_two_flag,
   input  wire        upper_bound_two_flag,
   input  wire        reading_ready,
   input  wire        buffer_has_pair,
   input  wire        buffer_half,
   input  wire        buffer_complete,
   // questionable status
   input  wire        ref_junction_bad,
   input  wire        cal_const_bad,
   input  wire        cal_done_ok,
   input  wire        cmd_param_ignored,
   // operation status
   input  wire        meas_busy,
   input  wire        trig_action,
   input  wire        dev_idle,
   // host access
   input  wire [1:0]  host_sel,
   input  wire        host_evt_rd,
   input  wire        host_cond_rd,
   input  wire        host_ena_wr,
   input  wire [15:0] host_ena_data,
   input  wire        host_preset,
   // host answer
   output reg  [15:0] host_rdata,
   output reg  [19:0] host_rdata_dec,
   output reg         host_rvalid,
   // status outputs
   output reg         cal_use_default,
   output reg         err_indicator,
   output reg         meas_summary,
   output reg         ques_summary,
   output reg         oper_summary
);
   reg         rst_s1_q;
   reg         rst_sync_b;
   reg         cal_bad_q;
   wire [15:0] meas_cond;
   wire [15:0] ques_cond;
   wire [15:0] oper_cond;
   wire [15:0] m_cond;
   wire [15:0] m_evt;
   wire [15:0] m_ena;
   wire [15:0] q_cond;
   wire [15:0] q_evt;
   wire [15:0] q_ena;
   wire [15:0] o_cond;
   wire [15:0] o_evt;
   wire [15:0] o_ena;
   wire        m_sum;
   wire        q_sum;
   wire        o_sum;
   reg  [15:0] sel_val;
   reg  [19:0] dec_val;
   reg  [15:0] bin_tmp;
   integer     i;

   // reset release through two flops
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q   <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_s1_q   <= 1'b1;
         rst_sync_b <= rst_s1_q;
      end
   end

   // calibration fault held until a good calibration
   always @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b)
         cal_bad_q <= 1'b0;
      else if (cal_const_bad)
         cal_bad_q <= 1'b1;
      else if (cal_done_ok)
         cal_bad_q <= 1'b0;
   end

   assign meas_cond = {6'h00,
                       buffer_complete,
                       buffer_half,
                       buffer_has_pair,
                       1'b0,
                       reading_ready,
                       upper_bound_two_flag,
                       lower_bound_two_flag,
                       upper_bound_one_flag,
                       lower_bound_one_flag,
                       reading_overflow};

   assign ques_cond = {1'b0,
                       cmd_param_ignored,
                       5'h00,
                       cal_bad_q,
                       3'h0,
                       ref_junction_bad,
                       4'h0};

   assign oper_cond = {5'h00,
                       dev_idle,
                       4'h0,
                       trig_action,
                       meas_busy,
                       4'h0};

   ser_evt_reg #(.USED_MASK(`SER_MEAS_MASK)) u_meas (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .cond_in    (meas_cond),
      .rd_clr     (host_evt_rd && host_sel == `SER_SEL_MEAS),
      .ena_wr     (host_ena_wr && host_sel == `SER_SEL_MEAS),
      .ena_clr    (host_preset),
      .ena_data   (host_ena_data),
      .cond_q     (m_cond),
      .event_q    (m_evt),
      .ena_q      (m_ena),
      .summary_q  (m_sum)
   );

   ser_evt_reg #(.USED_MASK(`SER_QUES_MASK)) u_ques (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .cond_in    (ques_cond),
      .rd_clr     (host_evt_rd && host_sel == `SER_SEL_QUES),
      .ena_wr     (host_ena_wr && host_sel == `SER_SEL_QUES),
      .ena_clr    (host_preset),
      .ena_data   (host_ena_data),
      .cond_q     (q_cond),
      .event_q    (q_evt),
      .ena_q      (q_ena),
      .summary_q  (q_sum)
   );

   ser_evt_reg #(.USED_MASK(`SER_OPER_MASK)) u_oper (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .cond_in    (oper_cond),
      .rd_clr     (host_evt_rd && host_sel == `SER_SEL_OPER),
      .ena_wr     (host_ena_wr && host_sel == `SER_SEL_OPER),
      .ena_clr    (host_preset),
      .ena_data   (host_ena_data),
      .cond_q     (o_cond),
      .event_q    (o_evt),
      .ena_q      (o_ena),
      .summary_q  (o_sum)
   );

   // read mux: event value is sampled before its clear lands
   always @* begin
      sel_val = 16'h0000;
      case (host_sel)
         `SER_SEL_MEAS: sel_val = host_cond_rd ? m_cond : m_evt;
         `SER_SEL_QUES: sel_val = host_cond_rd ? q_cond : q_evt;
         `SER_SEL_OPER: sel_val = host_cond_rd ? o_cond : o_evt;
         default:       sel_val = 16'h0000;
      endcase
   end

   // double-dabble to five decimal digits
   always @* begin
      dec_val = 20'h00000;
      bin_tmp = sel_val;
      for (i = 0; i < 16; i = i + 1) begin
         if (dec_val[3:0]   > 4'h4) dec_val[3:0]   = dec_val[3:0]   + 4'h3;
         if (dec_val[7:4]   > 4'h4) dec_val[7:4]   = dec_val[7:4]   + 4'h3;
         if (dec_val[11:8]  > 4'h4) dec_val[11:8]  = dec_val[11:8]  + 4'h3;
         if (dec_val[15:12] > 4'h4) dec_val[15:12] = dec_val[15:12] + 4'h3;
         if (dec_val[19:16] > 4'h4) dec_val[19:16] = dec_val[19:16] + 4'h3;
         dec_val = {dec_val[18:0], bin_tmp[15]};
         bin_tmp = {bin_tmp[14:0], 1'b0};
      end
   end

   always @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         host_rdata      <= 16'h0000;
         host_rdata_dec  <= 20'h00000;
         host_rvalid     <= 1'b0;
         cal_use_default <= 1'b0;
         err_indicator   <= 1'b0;
         meas_summary    <= 1'b0;
         ques_summary    <= 1'b0;
         oper_summary    <= 1'b0;
      end else begin
         host_rvalid <= host_evt_rd | host_cond_rd;
         if (host_evt_rd | host_cond_rd) begin
            host_rdata     <= sel_val;
            host_rdata_dec <= dec_val;
         end
         cal_use_default <= cal_bad_q;
         err_indicator   <= |q_evt;
         meas_summary    <= m_sum;
         ques_summary    <= q_sum;
         oper_summary    <= o_sum;
      end
   end
endmodule // ser_status_top

//--- verilog/ser_consts.vh
// ser_consts.vh: constants for the status event register block.
// assumes inclusion by bare name from every design file; definitions only.
// Function
// - read returns contents then clears register
// - query answers decimal value of register bits
// - overflow sets measurement bit 0
// - limit one low/high set bits 1, 2
// - limit two low/high set bits 3, 4
// - processed reading sets measurement bit 5
// - two buffered readings set measurement bit 7
// - half-full buffer sets measurement bit 8
// - full buffer sets measurement bit 9
// - invalid reference junction sets questionable bit 4
// - bad calibration constant sets questionable bit 8
// - bad calibration constant replaced by default
// - bad calibration held until calibration succeeds
// - ignored command parameter sets questionable bit 14
// - error indicator follows questionable events
// - measuring sets operation bit 4
// - device action stage sets operation bit 5
// - idle state sets operation bit 10
// - enable mask gates event onto summary
// - condition register tracks status, event latches
`ifndef SER_CONSTS_VH
`define SER_CONSTS_VH

`define SER_W            16
// register select codes
`define SER_SEL_MEAS     2'h0
`define SER_SEL_QUES     2'h1
`define SER_SEL_OPER     2'h2
// measurement bits
`define SER_M_OVF        0
`define SER_M_LO1        1
`define SER_M_HI1        2
`define SER_M_LO2        3
`define SER_M_HI2        4
`define SER_M_RDY        5
`define SER_M_PAIR       7
`define SER_M_HALF       8
`define SER_M_FULL       9
`define SER_MEAS_MASK    16'h03BF
// questionable bits
`define SER_Q_TEMP       4
`define SER_Q_CAL        8
`define SER_Q_WARN       14
`define SER_QUES_MASK    16'h4110
// operation bits
`define SER_O_MEAS       4
`define SER_O_TRIG       5
`define SER_O_IDLE       10
`define SER_OPER_MASK    16'h0430
// reset values
`define SER_EVT_RST      16'h0000
`define SER_ENA_RST      16'h0000
// decimal answer: five digits of four bits
`define SER_DEC_W        20

`endif

//--- verilog/ser_evt_reg.v
// ser_evt_reg.v: one latched event register with condition, mask and summary.
// assumes single clock domain and a synchronised active-low reset.
`timescale 1ns/1ps
`include "ser_consts.vh"
module ser_evt_reg #(
   parameter [15:0] USED_MASK = 16'hFFFF
) (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_sync_b,
   // live condition bits
   input  wire [15:0] cond_in,
   // host access
   input  wire        rd_clr,
   input  wire        ena_wr,
   input  wire        ena_clr,
   input  wire [15:0] ena_data,
   // state out
   output reg  [15:0] cond_q,
   output reg  [15:0] event_q,
   output reg  [15:0] ena_q,
   output reg         summary_q
);
   reg  [15:0] cond_prev_q;
   wire [15:0] rise_set;
   wire [15:0] event_d;

   // event latches rising edges of the condition
   assign rise_set = cond_in & ~cond_prev_q & USED_MASK;
   // new set survives a clearing read
   assign event_d  = ((rd_clr ? 16'h0000 : event_q) | rise_set) & USED_MASK;

   always @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cond_prev_q <= 16'h0000;
         cond_q      <= 16'h0000;
         event_q     <= `SER_EVT_RST;
         ena_q       <= `SER_ENA_RST;
         summary_q   <= 1'b0;
      end else begin
         cond_prev_q <= cond_in & USED_MASK;
         cond_q      <= cond_in & USED_MASK;
         event_q     <= event_d;
         if (ena_clr)
            ena_q <= 16'h0000;
         else if (ena_wr)
            ena_q <= ena_data & USED_MASK;
         summary_q   <= |(event_d & ena_q);
      end
   end
endmodule // ser_evt_reg

//--- bench/ser_status_assertions.sv
// checks on the ports of the status event block.
// assumes a bind to ser_status_top; one clock, rst_b active low.
`timescale 1ns/1ps
`include "ser_consts.vh"
module ser_status_assertions (
   // clock and reset
   input wire        core_clk,
   input wire        rst_b,
   // host side
   input wire [1:0]  host_sel,
   input wire        host_evt_rd,
   input wire        host_cond_rd,
   input wire        host_ena_wr,
   input wire        host_preset,
   input wire [15:0] host_rdata,
   input wire        host_rvalid,
   // status lines
   input wire        ref_junction_bad,
   input wire        cal_const_bad,
   input wire        cal_done_ok,
   input wire        cmd_param_ignored,
   input wire        cal_use_default,
   input wire        err_indicator,
   input wire        meas_summary
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire       rd_any = host_evt_rd | host_cond_rd;
   wire       q_any  = ref_junction_bad | cal_const_bad | cmd_param_ignored;
   wire       q_read = host_evt_rd && host_sel == `SER_SEL_QUES;
   reg [15:0] used_q;
   // bits that may show in the pending answer
   always @(posedge core_clk) begin
      if (rd_any)
         used_q <= host_sel == `SER_SEL_MEAS ? `SER_MEAS_MASK :
                   host_sel == `SER_SEL_QUES ? `SER_QUES_MASK :
                   host_sel == `SER_SEL_OPER ? `SER_OPER_MASK : 16'h0000;
   end
   sequence s_ques_rise;
      !q_any ##1 q_any;
   endsequence
   sequence s_ques_clear;
      !q_any [*2] ##1 (q_read && !q_any) ##1 !q_any;
   endsequence
   sequence s_preset_quiet;
      host_preset ##1 !host_ena_wr [*3];
   endsequence
   chk_read_answer: assert property (rd_any |=> host_rvalid)
      else $error("read got no answer");
   chk_answer_lone: assert property (!rd_any |=> !host_rvalid)
      else $error("answer without read");
   chk_unused_zero: assert property (
      host_rvalid |-> (host_rdata & ~used_q) == 16'h0000)
      else $error("unused bit set");
   chk_err_raise: assert property (s_ques_rise |-> ##[1:4] err_indicator)
      else $error("indicator stayed off");
   chk_err_drop: assert property (s_ques_clear |=> !err_indicator)
      else $error("indicator stayed on");
   chk_cal_default: assert property (
      $rose(cal_const_bad) |-> ##[1:3] cal_use_default)
      else $error("default constant not used");
   chk_cal_hold: assert property (
      cal_use_default && !cal_done_ok && !$past(cal_done_ok) && !$past(cal_done_ok, 2)
      |=> cal_use_default)
      else $error("cal fault dropped early");
   chk_preset_mask: assert property (s_preset_quiet |-> !meas_summary)
      else $error("summary after preset");
endmodule // ser_status_assertions

//--- bench/ser_host_model.sv
// remote host: status queries and enable writes.
// assumes the answer comes one cycle after the strobe.
`timescale 1ns/1ps
module ser_host_model (
   // clock
   input wire        core_clk,
   // answer
   input wire [15:0] host_rdata,
   input wire [19:0] host_rdata_dec,
   input wire        host_rvalid,
   // requests
   output reg [1:0]  host_sel,
   output reg        host_evt_rd,
   output reg        host_cond_rd,
   output reg        host_ena_wr,
   output reg [15:0] host_ena_data,
   output reg        host_preset
);
   initial begin
      host_sel = 2'h3;
      host_evt_rd = 1'b0;
      host_cond_rd = 1'b0;
      host_ena_wr = 1'b0;
      host_ena_data = 16'h0000;
      host_preset = 1'b0;
   end
   task query(input evt, input [1:0] sel, output [15:0] bin, output [19:0] dec,
              output ok);
      begin
         @(posedge core_clk);
         host_sel <= sel;
         host_evt_rd <= evt;
         host_cond_rd <= !evt;
         @(posedge core_clk);
         host_evt_rd <= 1'b0;
         host_cond_rd <= 1'b0;
         host_sel <= ~sel;
         #1;
         ok = host_rvalid;
         bin = host_rdata;
         dec = host_rdata_dec;
      end
   endtask
   task ena_write(input [1:0] sel, input [15:0] val, input pre);
      begin
         @(posedge core_clk);
         host_sel <= sel;
         host_ena_data <= val;
         host_ena_wr <= !pre;
         host_preset <= pre;
         @(posedge core_clk);
         host_ena_wr <= 1'b0;
         host_preset <= 1'b0;
         host_ena_data <= ~val;
      end
   endtask
endmodule // ser_host_model

//--- bench/ser_status_top_test.sv
// bench for the status event registers.
// assumes ser_host_model for host traffic and the bound checker.
`timescale 1ns/1ps
`include "ser_consts.vh"
module ser_status_top_test;
   reg         core_clk, rst_b, cal_ok, ok;
   reg  [15:0] mv, qv, ov, bin, acc;
   reg  [19:0] dec;
   wire [1:0]  host_sel;
   wire        host_evt_rd, host_cond_rd, host_ena_wr, host_preset, host_rvalid;
   wire [15:0] host_ena_data, host_rdata;
   wire [19:0] host_rdata_dec;
   wire        cal_use_default, err_indicator, meas_summary, ques_summary, oper_summary;
   integer     err_total, n_tests, s, b, k;
   ser_status_top u_dut (.core_clk, .rst_b, .reading_overflow(mv[0]),
      .lower_bound_one_flag(mv[1]), .upper_bound_one_flag(mv[2]),
      .lower_bound_two_flag(mv[3]), .upper_bound_two_flag(mv[4]), .reading_ready(mv[5]),
      .buffer_has_pair(mv[7]), .buffer_half(mv[8]), .buffer_complete(mv[9]),
      .ref_junction_bad(qv[4]), .cal_const_bad(qv[8]), .cal_done_ok(cal_ok),
      .cmd_param_ignored(qv[14]), .meas_busy(ov[4]), .trig_action(ov[5]), .dev_idle(ov[10]),
      .host_sel, .host_evt_rd, .host_cond_rd, .host_ena_wr, .host_ena_data, .host_preset,
      .host_rdata, .host_rdata_dec, .host_rvalid, .cal_use_default, .err_indicator,
      .meas_summary, .ques_summary, .oper_summary);
   ser_host_model u_host (.core_clk, .host_rdata, .host_rdata_dec, .host_rvalid, .host_sel,
      .host_evt_rd, .host_cond_rd, .host_ena_wr, .host_ena_data, .host_preset);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   function [19:0] to_bcd(input [15:0] v);
      integer i;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            to_bcd[i*4 +: 4] = v % 10;
            v = v / 10;
         end
      end
   endfunction
   task check(input [19:0] seen, input [19:0] want);
      begin
         n_tests = n_tests + 1;
         if (seen !== want) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
         end
      end
   endtask
   task rd(input evt, input [1:0] sel, input [15:0] want);
      begin
         u_host.query(evt, sel, bin, dec, ok);
         check(ok, 1'b1);
         check(bin, want);
         check(dec, to_bcd(want));
      end
   endtask
   task hit(input [1:0] sel, input integer bit_no);
      begin
         @(posedge core_clk);
         if (sel == 2'h0) mv[bit_no] <= 1'b1;
         else if (sel == 2'h1) qv[bit_no] <= 1'b1;
         else ov[bit_no] <= 1'b1;
         repeat (2) @(posedge core_clk);
         mv <= 16'h0000;
         qv <= 16'h0000;
         ov <= 16'h0000;
         repeat (4) @(posedge core_clk);
         #1;
         if (sel == 2'h1) check(err_indicator, 1'b1);
         rd(1'b1, sel, 16'h0001 << bit_no);
         rd(1'b1, sel, 16'h0000);
         repeat (3) @(posedge core_clk);
         #1;
         check(err_indicator, 1'b0);
         if (sel == 2'h1 && bit_no == 8) begin
            check(cal_use_default, 1'b1);
            @(posedge core_clk);
            cal_ok <= 1'b1;
            @(posedge core_clk);
            cal_ok <= 1'b0;
            repeat (3) @(posedge core_clk);
            #1;
            check(cal_use_default, 1'b0);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #200000;
      err_total = err_total + 1;
      report_and_stop;
   end
   initial begin
      err_total = 0;
      n_tests = 0;
      rst_b = 1'b0;
      cal_ok = 1'b0;
      mv = 16'h0000;
      qv = 16'h0000;
      ov = 16'h0000;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge core_clk);
      for (s = 0; s < 3; s = s + 1) begin
         acc = s == 0 ? `SER_MEAS_MASK : s == 1 ? `SER_QUES_MASK : `SER_OPER_MASK;
         for (b = 0; b < 16; b = b + 1)
            if (acc[b]) hit(s[1:0], b);
      end
      // the read edge slides across the moment the event latches
      // k = 1 puts the latch edge on the clearing read edge
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge core_clk);
         fork
            begin
               repeat (k) @(posedge core_clk);
               mv[5] <= 1'b1;
            end
            u_host.query(1'b1, `SER_SEL_MEAS, acc, dec, ok);
         join
         u_host.query(1'b1, `SER_SEL_MEAS, bin, dec, ok);
         check(acc | bin, 16'h0020);
         check(acc & bin, 16'h0000);
         @(posedge core_clk);
         mv[5] <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      u_host.ena_write(`SER_SEL_MEAS, 16'h0020, 1'b0);
      @(posedge core_clk);
      mv[0] <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      check(meas_summary, 1'b0);
      @(posedge core_clk);
      mv[5] <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      check(meas_summary, 1'b1);
      rd(1'b0, `SER_SEL_MEAS, 16'h0021);
      rd(1'b0, 2'h3, 16'h0000);
      u_host.ena_write(`SER_SEL_QUES, 16'h0010, 1'b0);
      u_host.ena_write(`SER_SEL_OPER, 16'h0400, 1'b0);
      #1;
      check(ques_summary, 1'b0);
      check(oper_summary, 1'b0);
      @(posedge core_clk);
      qv[4] <= 1'b1;
      ov[10] <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      check(ques_summary, 1'b1);
      check(oper_summary, 1'b1);
      u_host.ena_write(`SER_SEL_MEAS, 16'h0000, 1'b1);
      repeat (4) @(posedge core_clk);
      #1;
      check(meas_summary, 1'b0);
      check(ques_summary, 1'b0);
      check(oper_summary, 1'b0);
      rd(1'b1, `SER_SEL_MEAS, 16'h0021);
      rd(1'b1, `SER_SEL_MEAS, 16'h0000);
      report_and_stop;
   end
endmodule // ser_status_top_test
bind ser_status_top ser_status_assertions u_chk (
   .core_clk, .rst_b, .host_sel, .host_evt_rd, .host_cond_rd, .host_ena_wr, .host_preset,
   .host_rdata, .host_rvalid, .ref_junction_bad, .cal_const_bad, .cal_done_ok,
   .cmd_param_ignored, .cal_use_default, .err_indicator, .meas_summary);
